// [shared/pps_pkg.sv]
// shared constants and types for the passive serial target loader
// assumes a 125 MHz system clock; link signals arrive asynchronously
package pps_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    // longest reset time-out before the status line is released
    localparam int RESET_TIMEOUT_NS = 40000;
    localparam int RESET_TIMEOUT_CYC = RESET_TIMEOUT_NS / CLK_PERIOD_NS;
    // start-up clocks spent in initialization
    localparam logic [7:0] INIT_CLOCKS = 8'h10;

    // ------------------------------------------------------------------
    // image layout
    // ------------------------------------------------------------------
    localparam logic [15:0] IMAGE_BITS_DEFAULT = 16'h0040;
    localparam int SYNC_WIDTH = 6;

    // ------------------------------------------------------------------
    // sequencer states, gray along the load path
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET = 3'h0,
        ST_WAIT = 3'h1,
        ST_LOAD = 3'h3,
        ST_DONE_WAIT = 3'h2,
        ST_INIT = 3'h6,
        ST_USER = 3'h7,
        ST_ERROR = 3'h5
    } pps_state_t;

endpackage : pps_pkg

// [design/pps_sync2.sv]
// two-flop synchroniser, one chain per bit
// assumes inputs are asynchronous to i_clk
module pps_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // async in, synced out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------------
    // per-bit chains
    // ------------------------------------------------------------------
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        always_ff @(posedge i_clk) begin
            if (!i_reset_n) begin
                meta[g] <= 1'b0;
                o_sync[g] <= 1'b0;
            end else begin
                meta[g] <= i_async[g];
                o_sync[g] <= meta[g];
            end
        end
    end

endmodule : pps_sync2

// [design/pps_target.sv]
// passive serial configuration target: one lane, chain enable, shared status/done
// assumes status and done are open-drain wires resolved outside this module
//
// Overview of operation
// - identical-data targets start and finish loading together
// - any target error halts the whole chain; reload from the start
// - restart input may come from memory init output to start loading
// - mixed chains share done and status; finish and error together
// - initialization clocked by internal clock or user start-up clock
// - auto restart releases status after at most 40 us reset
// - finished target drives chain enable output low for the next
module pps_target #(
    parameter int RESET_TIMEOUT_CYC = pps_pkg::RESET_TIMEOUT_CYC,
    parameter logic [15:0] IMAGE_BITS = pps_pkg::IMAGE_BITS_DEFAULT
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // serial link
    input wire logic I_SERIAL_CFG_CLOCK,
    input wire logic I_SERIAL_CFG_DATA_LANE0,
    input wire logic I_CHAIN_ENABLE_IN_N,
    output logic O_CHAIN_ENABLE_OUT_N,
    // shared status line, open drain
    input wire logic I_STATUS_N,
    output logic O_STATUS_N,
    output logic O_STATUS_N_OE,
    // shared done line, open drain
    input wire logic I_CFG_DONE,
    output logic O_CFG_DONE,
    output logic O_CFG_DONE_OE,
    // restart and options
    input wire logic I_CFG_RESTART_N,
    input wire logic I_AUTO_RESTART,
    input wire logic I_USE_STARTUP_CLOCK,
    input wire logic I_USER_STARTUP_CLOCK,
    // loaded data and state
    output logic [7:0] O_CFG_DATA,
    output logic O_CFG_DATA_VALID,
    output logic O_USER_MODE,
    output logic O_CFG_ERROR
);
    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    logic [pps_pkg::SYNC_WIDTH-1:0] sync_out;
    logic clk_s, data_s, ce_s, status_s, done_s, restart_s, usr_s;
    logic clk_prev, usr_prev, clk_rise, usr_rise, init_tick;

    pps_sync2 #(.WIDTH(pps_pkg::SYNC_WIDTH + 1)) u_sync (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_async({I_USER_STARTUP_CLOCK, I_CFG_RESTART_N, I_CFG_DONE, I_STATUS_N,
                  I_CHAIN_ENABLE_IN_N, I_SERIAL_CFG_DATA_LANE0, I_SERIAL_CFG_CLOCK}),
        .o_sync({usr_s, sync_out})
    );
    assign {restart_s, done_s, status_s, ce_s, data_s, clk_s} = sync_out;

    assign clk_rise = clk_s && !clk_prev;
    assign usr_rise = usr_s && !usr_prev;
    // internal clock ticks every cycle unless the user clock is chosen
    assign init_tick = I_USE_STARTUP_CLOCK ? usr_rise : 1'b1;

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    pps_pkg::pps_state_t state, next_state;
    logic [15:0] timer, next_timer;
    logic [15:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic parity, next_parity;
    logic [7:0] data, next_data;
    logic valid, next_valid;
    logic [7:0] init_cnt, next_init_cnt;
    logic [15:0] timeout_last;

    assign timeout_last = 16'(RESET_TIMEOUT_CYC - 1);

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_parity = parity;
        next_data = data;
        next_valid = 1'b0;
        next_init_cnt = init_cnt;
        if (!restart_s) begin
            // restart held low keeps the chain in reset
            next_state = pps_pkg::ST_RESET;
            next_timer = 16'h0000;
        end else begin
            unique case (state)
                pps_pkg::ST_RESET: begin
                    if (timer == timeout_last) begin
                        next_state = pps_pkg::ST_WAIT;
                        next_timer = 16'h0000;
                    end else begin
                        next_timer = timer + 16'h0001;
                    end
                end
                pps_pkg::ST_WAIT: begin
                    next_bit_cnt = 16'h0000;
                    next_parity = 1'b0;
                    next_shift = 8'h00;
                    // identical-data targets leave here on the same edge
                    if (status_s && !ce_s) begin
                        next_state = pps_pkg::ST_LOAD;
                    end
                end
                pps_pkg::ST_LOAD: begin
                    if (!status_s) begin
                        next_state = pps_pkg::ST_WAIT;
                    end else if (clk_rise) begin
                        next_shift = {shift[6:0], data_s};
                        next_parity = parity ^ data_s;
                        next_bit_cnt = bit_cnt + 16'h0001;
                        if (bit_cnt[2:0] == 3'h7) begin
                            next_data = {shift[6:0], data_s};
                            next_valid = 1'b1;
                        end
                        // last bit closes even parity over the whole image
                        if (bit_cnt == IMAGE_BITS - 16'h0001) begin
                            next_timer = 16'h0000;
                            next_state = (parity ^ data_s) ? pps_pkg::ST_ERROR
                                                           : pps_pkg::ST_DONE_WAIT;
                        end
                    end
                end
                pps_pkg::ST_DONE_WAIT: begin
                    next_init_cnt = 8'h00;
                    if (!status_s) begin
                        next_state = pps_pkg::ST_WAIT;
                    end else if (done_s) begin
                        // shared done rises only when every target released it
                        next_state = pps_pkg::ST_INIT;
                    end
                end
                pps_pkg::ST_INIT: begin
                    if (!status_s) begin
                        next_state = pps_pkg::ST_WAIT;
                    end else if (init_tick) begin
                        next_init_cnt = init_cnt + 8'h01;
                        if (init_cnt == pps_pkg::INIT_CLOCKS - 8'h01) begin
                            next_state = pps_pkg::ST_USER;
                        end
                    end
                end
                pps_pkg::ST_USER: begin
                    next_state = pps_pkg::ST_USER;
                end
                pps_pkg::ST_ERROR: begin
                    // without auto restart only the restart input recovers
                    if (I_AUTO_RESTART) begin
                        if (timer == timeout_last) begin
                            next_state = pps_pkg::ST_WAIT;
                            next_timer = 16'h0000;
                        end else begin
                            next_timer = timer + 16'h0001;
                        end
                    end
                end
                default: begin
                    next_state = pps_pkg::ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            state <= pps_pkg::ST_RESET;
            timer <= 16'h0000;
            bit_cnt <= 16'h0000;
            shift <= 8'h00;
            parity <= 1'b0;
            data <= 8'h00;
            valid <= 1'b0;
            init_cnt <= 8'h00;
            clk_prev <= 1'b0;
            usr_prev <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            parity <= next_parity;
            data <= next_data;
            valid <= next_valid;
            init_cnt <= next_init_cnt;
            clk_prev <= clk_s;
            usr_prev <= usr_s;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic finished;
    assign finished = (state == pps_pkg::ST_DONE_WAIT) || (state == pps_pkg::ST_INIT)
                      || (state == pps_pkg::ST_USER);

    // an error pulls the shared status low, halting every target
    assign O_STATUS_N = 1'b0;
    assign O_STATUS_N_OE = (state == pps_pkg::ST_RESET) || (state == pps_pkg::ST_ERROR);
    // done is held low until this target has its whole image
    assign O_CFG_DONE = 1'b0;
    assign O_CFG_DONE_OE = !finished;
    assign O_CHAIN_ENABLE_OUT_N = !finished;
    assign O_CFG_DATA = data;
    assign O_CFG_DATA_VALID = valid;
    assign O_USER_MODE = (state == pps_pkg::ST_USER);
    assign O_CFG_ERROR = (state == pps_pkg::ST_ERROR);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    a_chain_enable_out: assert property (
        (state == pps_pkg::ST_LOAD && next_state == pps_pkg::ST_DONE_WAIT && restart_s)
        |=> !O_CHAIN_ENABLE_OUT_N ##1 !O_CHAIN_ENABLE_OUT_N)
        else $error("chain enable output not driven low after load");
    a_capture_rise: assert property (
        (state == pps_pkg::ST_LOAD && status_s && restart_s && clk_rise)
        |=> bit_cnt == $past(bit_cnt) + 16'h0001)
        else $error("rising serial clock did not capture a bit");
    a_no_capture_idle: assert property (
        (state == pps_pkg::ST_LOAD && !clk_rise) |=> $stable(bit_cnt))
        else $error("bit captured without serial clock edge");
    a_error_halts: assert property (
        (restart_s && !status_s && (state == pps_pkg::ST_LOAD || state == pps_pkg::ST_INIT))
        |=> state == pps_pkg::ST_WAIT)
        else $error("chain error did not halt loading");
    a_restart_resets: assert property (
        !restart_s |=> state == pps_pkg::ST_RESET && O_STATUS_N_OE)
        else $error("restart did not reset the target");
    a_done_gates_init: assert property (
        (state == pps_pkg::ST_DONE_WAIT && !done_s) |=> state != pps_pkg::ST_INIT)
        else $error("initialization began before shared done");
    a_timeout_bound: assert property (
        (state == pps_pkg::ST_ERROR) |-> timer <= timeout_last)
        else $error("reset time-out exceeded");
    a_auto_release: assert property (
        (state == pps_pkg::ST_ERROR && I_AUTO_RESTART && restart_s && timer == timeout_last)
        |=> !O_STATUS_N_OE)
        else $error("status not released after reset time-out");
    a_user_clock_init: assert property (
        (state == pps_pkg::ST_INIT && I_USE_STARTUP_CLOCK && !usr_rise)
        |=> $stable(init_cnt))
        else $error("initialization advanced without start-up clock");
    a_joint_start: assert property (
        (state == pps_pkg::ST_WAIT && restart_s && status_s && !ce_s)
        |=> state == pps_pkg::ST_LOAD)
        else $error("target did not start with the chain");

    c_byte_out: cover property (O_CFG_DATA_VALID);
    c_user_mode: cover property ($rose(O_USER_MODE));
    c_parity_error: cover property ($rose(O_CFG_ERROR));
    c_auto_retry: cover property (state == pps_pkg::ST_ERROR ##1 state == pps_pkg::ST_WAIT);

endmodule : pps_target

// [bench/pps_mem_model.sv]
// behavioural serial configuration memory driving one data lane
// assumes status and done are resolved open-drain wires in the bench
module pps_mem_model #(
    parameter int HALF_NS = 80,
    parameter int WAIT_CLOCKS = 64
) (
    // frame request from the bench
    input wire logic i_go,
    input wire logic [15:0] i_image,
    // shared lines
    input wire logic i_status_n,
    input wire logic i_cfg_done,
    // link outputs
    output logic o_serial_cfg_clock,
    output logic o_serial_cfg_data_lane0,
    output logic o_status_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------------
    task automatic send_frame();
        int n;
        bit ok;
        ok = 1'b1;
        // single lane, msb first, one bit per clock
        for (n = 15; n >= 0 && ok; n--) begin
            o_serial_cfg_data_lane0 = i_image[n];
            #(HALF_NS) o_serial_cfg_clock = 1'b1;
            // next bit follows at once, no gap in the stream
            #(HALF_NS) o_serial_cfg_clock = 1'b0;
            ok = i_status_n;
        end
        // released line must not keep the last bit
        o_serial_cfg_data_lane0 = ~o_serial_cfg_data_lane0;
        for (n = 0; n < WAIT_CLOCKS && ok && !i_cfg_done; n++) begin
            #(HALF_NS) o_serial_cfg_clock = 1'b1;
            #(HALF_NS) o_serial_cfg_clock = 1'b0;
        end
        if (ok && !i_cfg_done) begin
            o_status_pull = 1'b1;
            #(HALF_NS * 8) o_status_pull = 1'b0;
        end
    endtask : send_frame

    initial begin
        o_serial_cfg_clock = 1'b0;
        o_serial_cfg_data_lane0 = 1'b1;
        o_status_pull = 1'b0;
        forever begin
            @(posedge i_go);
            // keep link edges off the system clock edges
            #2;
            // selected only while done is low
            if (i_status_n && !i_cfg_done) begin
                send_frame();
            end
        end
    end
endmodule : pps_mem_model

// [bench/tb.sv]
// self-checking bench for the passive serial target
// assumes the target's assertions sit in the design files
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RTO = 20;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    // starts as a downstream target, so nothing loads before the chain test
    logic chain_in_n = 1'b1;
    logic restart_n = 1'b1;
    logic auto_rst = 1'b1;
    logic use_uclk = 1'b0;
    logic uclk = 1'b0;
    logic go = 1'b0;
    logic other_pull = 1'b0;
    logic [15:0] image = 16'h0000;
    logic sclk, sdata, mem_pull, st_oe, dn_oe, st_val, dn_val, ce_out_n, valid, user, cerr;
    logic [7:0] data;
    wire status_n = !((st_oe && !st_val) || mem_pull || other_pull);
    wire cfg_done = !(dn_oe && !dn_val);
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] seen[$];

    always #4 i_clk = ~i_clk;
    // offset keeps start-up clock edges off the system clock edges
    initial begin
        #2;
        forever #20 uclk = ~uclk;
    end
    always @(negedge i_clk) if (valid === 1'b1) seen.push_back(data);

    pps_target #(.RESET_TIMEOUT_CYC(RTO), .IMAGE_BITS(16'h0010)) u_pps_target (
        .I_CLK(i_clk), .I_RESET_N(i_reset_n), .I_SERIAL_CFG_CLOCK(sclk),
        .I_SERIAL_CFG_DATA_LANE0(sdata), .I_CHAIN_ENABLE_IN_N(chain_in_n),
        .O_CHAIN_ENABLE_OUT_N(ce_out_n), .I_STATUS_N(status_n), .O_STATUS_N(st_val),
        .O_STATUS_N_OE(st_oe), .I_CFG_DONE(cfg_done), .O_CFG_DONE(dn_val),
        .O_CFG_DONE_OE(dn_oe), .I_CFG_RESTART_N(restart_n), .I_AUTO_RESTART(auto_rst),
        .I_USE_STARTUP_CLOCK(use_uclk), .I_USER_STARTUP_CLOCK(uclk), .O_CFG_DATA(data),
        .O_CFG_DATA_VALID(valid), .O_USER_MODE(user), .O_CFG_ERROR(cerr));

    pps_mem_model u_pps_mem_model (.i_go(go), .i_image(image), .i_status_n(status_n),
        .i_cfg_done(cfg_done), .o_serial_cfg_clock(sclk), .o_serial_cfg_data_lane0(sdata),
        .o_status_pull(mem_pull));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic run_frame(input logic [15:0] img);
        seen.delete();
        image <= img;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
    endtask : run_frame

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        int n;
        repeat (20) @(posedge i_clk);
        check("status oe in reset", st_oe, 1'b1);
        check("done oe in reset", dn_oe, 1'b1);
        check("chain out in reset", ce_out_n, 1'b1);
        check("status value", st_val, 1'b0);
        i_reset_n <= 1'b1;
        for (n = 0; n < 200 && st_oe !== 1'b0; n++) @(posedge i_clk);
        check("status release span", 16'(n >= RTO && n <= RTO + 8), 16'h0001);
    endtask : t_reset

    task automatic t_refused();
        int n;
        chain_in_n <= 1'b1;
        run_frame(16'ha53c);
        for (n = 0; n < 3000 && status_n !== 1'b0; n++) @(posedge i_clk);
        check("bytes while disabled", 16'(seen.size()), 16'h0000);
        check("done oe while disabled", dn_oe, 1'b1);
        check("chain out while disabled", ce_out_n, 1'b1);
        chain_in_n <= 1'b0;
        for (n = 0; n < 300 && status_n !== 1'b1; n++) @(posedge i_clk);
        repeat (5) @(posedge i_clk);
    endtask : t_refused

    // shared by every good load; lo and hi bound the start-up span
    task automatic t_load(input logic [15:0] img, input int lo, input int hi);
        int n;
        run_frame(img);
        for (n = 0; n < 4000 && cfg_done !== 1'b1; n++) @(posedge i_clk);
        check("chain out after load", ce_out_n, 1'b0);
        check("byte count", 16'(seen.size()), 16'h0002);
        check("first byte", seen[0], img[15:8]);
        check("second byte", seen[1], img[7:0]);
        for (n = 0; n < 400 && user !== 1'b1; n++) @(posedge i_clk);
        check("start-up span", 16'(n >= lo && n <= hi), 16'h0001);
        check("user mode", user, 1'b1);
        repeat (200) @(posedge i_clk);
    endtask : t_load

    task automatic t_restart();
        int n;
        restart_n <= 1'b0;
        use_uclk <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("status oe on restart", st_oe, 1'b1);
        check("user left on restart", user, 1'b0);
        check("done pulled on restart", cfg_done, 1'b0);
        restart_n <= 1'b1;
        for (n = 0; n < 200 && st_oe !== 1'b0; n++) @(posedge i_clk);
        check("release after restart", 16'(n <= RTO + 8), 16'h0001);
    endtask : t_restart

    task automatic t_parity();
        int n;
        run_frame(16'ha53d);
        for (n = 0; n < 1000 && cerr !== 1'b1; n++) @(posedge i_clk);
        check("error flag", cerr, 1'b1);
        check("status pulled on error", st_oe, 1'b1);
        check("done stays low", cfg_done, 1'b0);
        for (n = 0; n < 200 && st_oe !== 1'b0; n++) @(posedge i_clk);
        check("auto release span", 16'(n >= RTO - 1 && n <= RTO + 3), 16'h0001);
        check("error cleared", cerr, 1'b0);
        repeat (40) @(posedge i_clk);
    endtask : t_parity

    // without auto restart only a restart pulse leaves the error state
    task automatic t_no_auto();
        int n;
        auto_rst <= 1'b0;
        run_frame(16'ha53d);
        for (n = 0; n < 1000 && cerr !== 1'b1; n++) @(posedge i_clk);
        repeat (RTO + 10) @(posedge i_clk);
        check("error held without auto", cerr, 1'b1);
        check("status held without auto", st_oe, 1'b1);
        restart_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        check("error left on restart", cerr, 1'b0);
        restart_n <= 1'b1;
        auto_rst <= 1'b1;
        for (n = 0; n < 200 && st_oe !== 1'b0; n++) @(posedge i_clk);
        check("release after manual restart", st_oe, 1'b0);
        repeat (40) @(posedge i_clk);
    endtask : t_no_auto

    task automatic t_abort();
        int n;
        run_frame(16'h0ff0);
        for (n = 0; n < 1000 && seen.size() != 1; n++) @(posedge i_clk);
        // held over one serial period so the memory sees it
        other_pull <= 1'b1;
        repeat (30) @(posedge i_clk);
        other_pull <= 1'b0;
        check("no error on foreign status", cerr, 1'b0);
        check("own status released", st_oe, 1'b0);
        check("chain out after abort", ce_out_n, 1'b1);
        repeat (40) @(posedge i_clk);
        t_load(16'h0ff0, 70, 95);
    endtask : t_abort

    // ------------------------------------------------------------------
    // sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        t_reset();
        $display("reset test done");
        t_refused();
        $display("chain enable test done");
        t_load(16'ha53c, 16, 24);
        $display("internal clock load test done");
        t_restart();
        $display("restart test done");
        t_parity();
        $display("parity error test done");
        t_no_auto();
        $display("no auto restart test done");
        t_abort();
        $display("abort and user clock load test done");
        give_verdict();
    end

    initial begin
        #400000;
        err_total++;
        give_verdict();
    end
endmodule : tb
